// [include/pma_pkg.sv]
`default_nettype none
package pma_pkg;
	// ==================================================================
	// Array geometry.
	localparam int NUM_MC = 16;
	localparam int NUM_DED = 4;
	localparam int NUM_BANK = 2;
	localparam int MC_PER_BANK = 8;
	localparam int NUM_SUM_PT = 8;
	localparam int PT_PER_MC = NUM_SUM_PT + 1;
	localparam int NUM_PT = NUM_MC * PT_PER_MC;
	localparam int NUM_IN = NUM_DED + NUM_MC;
	localparam int NUM_PIN_IN = NUM_DED + NUM_MC + NUM_BANK;
	localparam int SPLIT_W = 4;
	// ==================================================================
	// Power-up clear timing.
	localparam int POWERUP_CLEAR_TIME_US = 10;
	localparam int CLK_FREQ_MHZ = 200;
	localparam int POWERUP_CLEAR_CYC = POWERUP_CLEAR_TIME_US * CLK_FREQ_MHZ;
	localparam int CLR_CNT_W = $clog2(POWERUP_CLEAR_CYC);
	localparam logic [CLR_CNT_W-1:0] CLR_LAST =
		CLR_CNT_W'(POWERUP_CLEAR_CYC - 1);
	// ==================================================================
	// Register map.
	localparam int APB_AW = 12;
	localparam int APB_DW = 32;
	localparam logic [APB_AW-1:0] ADDR_CTRL = 12'h000;
	localparam logic [APB_AW-1:0] ADDR_STATUS = 12'h004;
	localparam logic [APB_AW-1:0] ADDR_QSTAT = 12'h008;
	localparam logic [APB_AW-1:0] ADDR_PINSTAT = 12'h00c;
	localparam int CTRL_RUN_BIT = 0;
	localparam int STAT_DONE_BIT = 0;
	localparam int STAT_RUN_BIT = 1;
	localparam int PT_REGION_BIT = 11;
	localparam int PT_IDX_LSB = 3;
	localparam int PT_IDX_W = 8;
	localparam int PT_COMP_BIT = 2;
	localparam logic [1:0] CFG_REGION = 2'h1;
	localparam int CFG_IDX_LSB = 2;
	localparam logic CTRL_RESET = 1'b0;
	localparam logic [NUM_IN-1:0] MASK_RESET = 20'h00000;
	// ==================================================================
	// Types.
	typedef enum logic [1:0]
	{
		FF_D = 2'h0,
		FF_T = 2'h1,
		FF_JK = 2'h3,
		FF_SR = 2'h2
	} pma_ff_type;
	typedef enum logic [1:0]
	{
		ST_CLEAR = 2'h0,
		ST_IDLE = 2'h1,
		ST_RUN = 2'h3
	} pma_state_type;
	typedef struct packed
	{
		logic registered;
		pma_ff_type ff;
		logic out_inv;
		logic pt_clock;
		logic pin_fb;
		logic [SPLIT_W-1:0] split;
		logic inv_a;
		logic inv_b;
	} pma_cfg_type;
	localparam int CFG_W = $bits(pma_cfg_type);
	localparam pma_cfg_type CFG_RESET = '0;
endpackage
`default_nettype wire

// [rtl/pma_macrocell.sv]
`timescale 1ns/100ps
`default_nettype none
module pma_macrocell
(
	// Clock and reset.
	input wire logic clk,
	input wire logic nrst,
	// Configuration and sequencing.
	input wire pma_pkg::pma_cfg_type cfg,
	input wire logic run,
	input wire logic clear,
	// Array terms and bank clock.
	input wire logic [pma_pkg::NUM_SUM_PT-1:0] sum_pt,
	input wire logic ctl_pt,
	input wire logic bank_edge,
	// Pin and feedback.
	input wire logic pin_in,
	output logic pin_out,
	output logic pin_oe,
	output logic fb,
	output logic q
);
	import pma_pkg::*;

	logic q_reg;
	logic q_next;
	logic ctl_prev_reg;
	logic tick;
	logic or_all;
	logic a_in;
	logic b_in;
	logic dt_type;
	logic [NUM_SUM_PT-1:0] a_mask;

	// ==================================================================
	// Term steering and input polarity.
	genvar i;
	generate
		for (i = 0; i < NUM_SUM_PT; i++)
		begin : g_split
			assign a_mask[i] = SPLIT_W'(i) < cfg.split;
		end
	endgenerate

	assign dt_type = (cfg.ff == FF_D) || (cfg.ff == FF_T);
	assign or_all = |sum_pt;
	assign a_in = (dt_type ? or_all : |(sum_pt & a_mask)) ^ cfg.inv_a;
	assign b_in = (|(sum_pt & ~a_mask)) ^ cfg.inv_b;

	// The term clock is edge detected on the system clock, so a term pulse
	// shorter than one cycle is lost.
	assign tick = run &&
		(cfg.pt_clock ? (ctl_pt && !ctl_prev_reg) : bank_edge);

	// ==================================================================
	// Storage element.
	always_comb
	begin
		case (cfg.ff)
			FF_D: q_next = a_in;
			FF_T: q_next = q_reg ^ a_in;
			FF_JK: q_next = (a_in && !q_reg) || (!b_in && q_reg);
			// Set with reset together is illegal; holding is the safe choice.
			default: q_next = (a_in && b_in) ? q_reg :
				(a_in || (q_reg && !b_in));
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
			ctl_prev_reg <= 1'b0;
		else
			ctl_prev_reg <= ctl_pt;
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
			q_reg <= 1'b0;
		else if (clear)
			q_reg <= 1'b0;
		else if (tick && cfg.registered)
			q_reg <= q_next;
	end

	// ==================================================================
	// Pin and feedback.
	assign q = q_reg;
	assign pin_out = (cfg.registered ? q_reg : or_all) ^
		cfg.out_inv;
	assign pin_oe = (cfg.registered && cfg.pt_clock) ? 1'b1 : ctl_pt;
	assign fb = (cfg.registered && !(dt_type && cfg.pin_fb)) ?
		q_reg : pin_in;

	// ==================================================================
	// Checks.
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	property p_d_load;
		(tick && cfg.registered && cfg.ff == FF_D && !clear)
			|=> q_reg == $past(a_in);
	endproperty
	a_d_load: assert property (p_d_load) else $error("D load wrong");

	property p_t_toggle;
		(tick && cfg.registered && cfg.ff == FF_T && !clear)
			|=> q_reg == ($past(q_reg) ^ $past(a_in));
	endproperty
	a_t_toggle: assert property (p_t_toggle) else $error("T wrong");

	property p_jk_both;
		(tick && cfg.registered && cfg.ff == FF_JK && a_in && b_in && !clear)
			|=> q_reg != $past(q_reg);
	endproperty
	a_jk_both: assert property (p_jk_both) else $error("JK no toggle");

	property p_pt_oe;
		(cfg.registered && cfg.pt_clock) |-> pin_oe;
	endproperty
	a_pt_oe: assert property (p_pt_oe) else $error("oe not forced");

	property p_fb_q;
		(cfg.registered && !dt_type) |-> fb == q_reg;
	endproperty
	a_fb_q: assert property (p_fb_q) else $error("JK/SR feedback");

	property p_idle_hold;
		!run |=> $stable(q_reg) || $past(clear);
	endproperty
	a_idle_hold: assert property (p_idle_hold) else $error("q moved idle");
endmodule
`default_nettype wire

// [rtl/pma_array.sv]
`timescale 1ns/100ps
`default_nettype none
module pma_array
(
	// Clock and reset.
	input wire logic clk,
	input wire logic nrst,
	// APB slave.
	input wire logic [pma_pkg::APB_AW-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [pma_pkg::APB_DW-1:0] pwdata,
	output logic [pma_pkg::APB_DW-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// Device pins.
	input wire logic [pma_pkg::NUM_DED-1:0] ded_in,
	input wire logic [pma_pkg::NUM_BANK-1:0] clk_pin,
	input wire logic [pma_pkg::NUM_MC-1:0] io_in,
	output logic [pma_pkg::NUM_MC-1:0] io_out,
	output logic [pma_pkg::NUM_MC-1:0] io_oe
);
	import pma_pkg::*;

	logic [NUM_PIN_IN-1:0] pin_meta_reg;
	logic [NUM_PIN_IN-1:0] pin_sync_reg;
	logic [NUM_BANK-1:0] bank_prev_reg;
	logic [NUM_DED-1:0] ded_s;
	logic [NUM_MC-1:0] io_s;
	logic [NUM_BANK-1:0] bank_s;
	logic [NUM_BANK-1:0] bank_edge;
	pma_state_type state_reg;
	pma_state_type state_next;
	logic [CLR_CNT_W-1:0] clr_cnt_reg;
	logic run_req_reg;
	logic clearing;
	logic running;
	logic [NUM_IN-1:0] pt_true_reg [NUM_PT];
	logic [NUM_IN-1:0] pt_comp_reg [NUM_PT];
	pma_cfg_type cfg_reg [NUM_MC];
	logic [NUM_IN-1:0] arr_in;
	logic [NUM_PT-1:0] pt_vec;
	logic [NUM_MC-1:0] fb;
	logic [NUM_MC-1:0] q_vec;
	logic [NUM_MC-1:0] inv_vec;
	logic [NUM_MC-1:0] reg_vec;
	logic [NUM_MC*CFG_W-1:0] cfg_flat;
	logic setup;
	logic access;
	logic wr_en;
	logic cfg_wr;
	logic bad;
	logic [APB_DW-1:0] prdata_reg;

	// ==================================================================
	// Address decode helpers.
	function automatic logic pt_hit(input logic [APB_AW-1:0] a);
		return a[PT_REGION_BIT] &&
			(a[PT_IDX_LSB +: PT_IDX_W] < PT_IDX_W'(NUM_PT));
	endfunction

	function automatic logic cfg_hit(input logic [APB_AW-1:0] a);
		return (a[APB_AW-1 -: 2] == CFG_REGION) &&
			(a[APB_AW-3:CFG_IDX_LSB+4] == '0);
	endfunction

	function automatic logic fixed_hit(input logic [APB_AW-1:0] a);
		return (a == ADDR_CTRL) || (a == ADDR_STATUS) ||
			(a == ADDR_QSTAT) || (a == ADDR_PINSTAT);
	endfunction

	// ==================================================================
	// Pin synchronisers.
	// Clock pins are sampled like data; the bank edge is seen two to three
	// cycles late, so outside setup times must cover that lag.
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			pin_meta_reg <= '0;
			pin_sync_reg <= '0;
			bank_prev_reg <= '0;
		end
		else
		begin
			pin_meta_reg <= {clk_pin, io_in, ded_in};
			pin_sync_reg <= pin_meta_reg;
			bank_prev_reg <= bank_s;
		end
	end

	assign ded_s = pin_sync_reg[NUM_DED-1:0];
	assign io_s = pin_sync_reg[NUM_DED +: NUM_MC];
	assign bank_s = pin_sync_reg[NUM_DED+NUM_MC +: NUM_BANK];
	assign bank_edge = bank_s & ~bank_prev_reg;

	// ==================================================================
	// Power-up clear and run sequencing.
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			ST_CLEAR:
				if (clr_cnt_reg == CLR_LAST)
					state_next = ST_IDLE;
			ST_IDLE:
				if (run_req_reg)
					state_next = ST_RUN;
			ST_RUN:
				if (!run_req_reg)
					state_next = ST_IDLE;
			default:
				state_next = ST_CLEAR;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
			state_reg <= ST_CLEAR;
		else
			state_reg <= state_next;
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
			clr_cnt_reg <= '0;
		else if (state_reg == ST_CLEAR)
			clr_cnt_reg <= clr_cnt_reg + 1'b1;
	end

	assign clearing = state_reg == ST_CLEAR;
	assign running = state_reg == ST_RUN;

	// ==================================================================
	// APB slave: no wait states; read data comes from a flip-flop loaded in the setup cycle.
	assign setup = psel && !penable;
	assign access = psel && penable;
	assign wr_en = access && pwrite;
	// Configuration may only change while the array is stopped.
	assign cfg_wr = wr_en && !running;
	assign bad = !(fixed_hit(paddr) || pt_hit(paddr) || cfg_hit(paddr)) ||
		(pwrite && running && (pt_hit(paddr) || cfg_hit(paddr)));
	assign pready = access;
	assign pslverr = access && bad;
	assign prdata = prdata_reg;

	always_ff @(posedge clk)
	begin
		if (!nrst)
			run_req_reg <= CTRL_RESET;
		else if (wr_en && paddr == ADDR_CTRL)
			run_req_reg <= pwdata[CTRL_RUN_BIT];
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			for (int p = 0; p < NUM_PT; p++)
			begin
				pt_true_reg[p] <= MASK_RESET;
				pt_comp_reg[p] <= MASK_RESET;
			end
		end
		else if (cfg_wr && pt_hit(paddr))
		begin
			if (paddr[PT_COMP_BIT])
				pt_comp_reg[paddr[PT_IDX_LSB +: PT_IDX_W]] <= pwdata[NUM_IN-1:0];
			else
				pt_true_reg[paddr[PT_IDX_LSB +: PT_IDX_W]] <= pwdata[NUM_IN-1:0];
		end
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			for (int m = 0; m < NUM_MC; m++)
				cfg_reg[m] <= CFG_RESET;
		end
		else if (cfg_wr && cfg_hit(paddr))
			cfg_reg[paddr[CFG_IDX_LSB +: 4]] <= pma_cfg_type'(pwdata[CFG_W-1:0]);
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
			prdata_reg <= '0;
		else if (setup && !pwrite)
		begin
			if (paddr == ADDR_CTRL)
				prdata_reg <= APB_DW'(run_req_reg);
			else if (paddr == ADDR_STATUS)
				prdata_reg <= APB_DW'({running, !clearing});
			else if (paddr == ADDR_QSTAT)
				prdata_reg <= APB_DW'(q_vec);
			else if (paddr == ADDR_PINSTAT)
				prdata_reg <= APB_DW'({io_oe, io_out});
			else if (pt_hit(paddr) && paddr[PT_COMP_BIT])
				prdata_reg <= APB_DW'(pt_comp_reg[paddr[PT_IDX_LSB +: PT_IDX_W]]);
			else if (pt_hit(paddr))
				prdata_reg <= APB_DW'(pt_true_reg[paddr[PT_IDX_LSB +: PT_IDX_W]]);
			else if (cfg_hit(paddr))
				prdata_reg <= APB_DW'(cfg_reg[paddr[CFG_IDX_LSB +: 4]]);
			else
				prdata_reg <= '0;
		end
	end

	// ==================================================================
	// AND array and macrocells.
	// Feedback is always a flop or a synchronised pin, so the array never
	// forms a combinational loop through itself.
	assign arr_in = {fb, ded_s};

	genvar p;
	generate
		for (p = 0; p < NUM_PT; p++)
		begin : g_pt
			assign pt_vec[p] = &(~pt_true_reg[p] | arr_in) &
				&(~pt_comp_reg[p] | ~arr_in);
		end
	endgenerate

	genvar m;
	generate
		for (m = 0; m < NUM_MC; m++)
		begin : g_mc
			pma_macrocell u_mc
			(
				.clk(clk),
				.nrst(nrst),
				.cfg(cfg_reg[m]),
				.run(running),
				.clear(clearing),
				.sum_pt(pt_vec[m*PT_PER_MC +: NUM_SUM_PT]),
				.ctl_pt(pt_vec[m*PT_PER_MC + NUM_SUM_PT]),
				.bank_edge(bank_edge[m / MC_PER_BANK]),
				.pin_in(io_s[m]),
				.pin_out(io_out[m]),
				.pin_oe(io_oe[m]),
				.fb(fb[m]),
				.q(q_vec[m])
			);
			assign inv_vec[m] = cfg_reg[m].out_inv;
			assign reg_vec[m] = cfg_reg[m].registered;
			assign cfg_flat[m*CFG_W +: CFG_W] = cfg_reg[m];
		end
	endgenerate

	// ==================================================================
	// Checks.
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	property p_clear_low;
		clearing |-> q_vec == '0;
	endproperty
	a_clear_low: assert property (p_clear_low) else $error("reg not clear");

	property p_clear_end;
		(clearing && clr_cnt_reg == CLR_LAST) |=> !clearing;
	endproperty
	a_clear_end: assert property (p_clear_end) else $error("clear too long");

	property p_clear_out;
		(!running && q_vec == '0) |-> ((io_out ^ inv_vec) & reg_vec) == '0;
	endproperty
	a_clear_out: assert property (p_clear_out) else $error("pin polarity");

	property p_pt_empty;
		(pt_true_reg[0] == '0 && pt_comp_reg[0] == '0) |-> pt_vec[0];
	endproperty
	a_pt_empty: assert property (p_pt_empty) else $error("empty term low");

	property p_pt_both;
		(|(pt_true_reg[2] & pt_comp_reg[2])) |-> !pt_vec[2];
	endproperty
	a_pt_both: assert property (p_pt_both) else $error("both term high");

	property p_cfg_static;
		(running && wr_en) |=> $stable(cfg_flat);
	endproperty
	a_cfg_static: assert property (p_cfg_static) else $error("cfg changed");

	property p_oe_pin;
		!(reg_vec[0] && cfg_reg[0].pt_clock) |-> io_oe[0] == pt_vec[NUM_SUM_PT];
	endproperty
	a_oe_pin: assert property (p_oe_pin) else $error("oe not term");

	property p_comb_or;
		!reg_vec[0] |->
			io_out[0] == ((|pt_vec[NUM_SUM_PT-1:0]) ^ inv_vec[0]);
	endproperty
	a_comb_or: assert property (p_comb_or) else $error("comb output");
endmodule
`default_nettype wire

// [dv/pma_sys_model.sv]
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// System logic that drives the dedicated, clock and I/O pins.
module pma_sys_model
(
	// Clock.
	input wire logic clk,
	// Requests from the bench.
	input wire logic [1:0] fire,
	input wire logic [3:0] ded_val,
	input wire logic [15:0] ext_val,
	// Device pin outputs.
	input wire logic [15:0] io_out,
	input wire logic [15:0] io_oe,
	// Pins seen by the device.
	output logic [3:0] ded_in,
	output logic [1:0] clk_pin,
	output logic [15:0] io_in,
	output logic busy
);
	logic [3:0] cnt_reg = 4'h0;
	logic [1:0] bank_reg = 2'h0;
	always_ff @(posedge clk)
	begin
		if (cnt_reg != 4'h0)
			cnt_reg <= cnt_reg + 4'h1;
		else if (fire != 2'h0)
		begin
			cnt_reg <= 4'h1;
			bank_reg <= fire;
		end
	end
	// The pin rises only once new inputs have had several cycles to settle.
	assign clk_pin = (cnt_reg >= 4'h5 && cnt_reg <= 4'h9) ? bank_reg : 2'h0;
	assign busy = cnt_reg != 4'h0;
	assign ded_in = ded_val;
	// A released pin is driven by the system side, so it never floats.
	assign io_in = (io_oe & io_out) | (~io_oe & ext_val);
endmodule
`default_nettype wire

// [dv/programmable_macrocell_array_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module programmable_macrocell_array_tb;
	import pma_pkg::*;
	typedef struct packed
	{
		logic [11:0] cfg;
		logic [3:0] ded;
		logic [1:0] bank;
		logic q;
	} pma_row_type;
	// Macrocell 0 sees D as the OR of ded_in[0] and ded_in[1], S or J from ded_in[0], and K (or R) from ded_in[1].
	pma_row_type rows [13] = '{'{12'h800, 4'h9, 2'h1, 1'b1},
		'{12'h800, 4'h8, 2'h1, 1'b0}, '{12'h800, 4'h9, 2'h2, 1'b0},
		'{12'h802, 4'h8, 2'h1, 1'b1}, '{12'ha00, 4'h9, 2'h1, 1'b0},
		'{12'ha00, 4'h8, 2'h1, 1'b0}, '{12'ha00, 4'h9, 2'h1, 1'b1},
		'{12'he04, 4'hb, 2'h1, 1'b0}, '{12'he04, 4'h9, 2'h1, 1'b1},
		'{12'he04, 4'ha, 2'h1, 1'b0}, '{12'hc04, 4'h9, 2'h1, 1'b1},
		'{12'hc04, 4'ha, 2'h1, 1'b0}, '{12'h900, 4'h9, 2'h1, 1'b1}};
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [APB_AW-1:0] paddr = '0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [APB_DW-1:0] pwdata = '0;
	logic [APB_DW-1:0] prdata;
	logic pready;
	logic pslverr;
	logic [1:0] fire = 2'h0;
	logic [1:0] clk_pin;
	logic [3:0] ded_val = 4'h8;
	logic [3:0] ded_in;
	logic [15:0] ext_val = 16'h00a5;
	logic [15:0] io_in;
	logic [15:0] io_out;
	logic [15:0] io_oe;
	logic busy;
	logic [31:0] rd;
	logic err;
	int n_errors = 0;
	int total_checks = 0;
	int cyc = 0;
	int t0;
	int i;
	pma_array dut_u (.clk(clk), .nrst(nrst), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ded_in(ded_in), .clk_pin(clk_pin), .io_in(io_in),
		.io_out(io_out), .io_oe(io_oe));
	pma_sys_model sys_u (.clk(clk), .fire(fire), .ded_val(ded_val),
		.ext_val(ext_val), .io_out(io_out), .io_oe(io_oe),
		.ded_in(ded_in), .clk_pin(clk_pin), .io_in(io_in), .busy(busy));
	always #2.5 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;
	// ==========================================================
	// Shared tasks.
	task automatic test_done();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		total_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic tmo(input string what);
		chk(32'h0, 32'h1, what);
		test_done();
	endtask
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 16);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 16)
			tmo("bus timeout");
		@(posedge clk);
	endtask
	task automatic pulse(input logic [1:0] b);
		int n;
		fire <= b;
		@(posedge clk);
		fire <= 2'h0;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (busy !== 1'b0 && n < 40);
		if (n >= 40)
			tmo("clock pulse timeout");
	endtask
	task automatic set_cfg(input logic [11:0] c);
		apb(1'b1, ADDR_CTRL, 32'h0);
		apb(1'b1, 12'h400, 32'(c));
		apb(1'b1, ADDR_CTRL, 32'h1);
	endtask
	// ==========================================================
	// Main sequence.
	initial
	begin
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		t0 = cyc;
		apb(1'b1, 12'h400, 32'h800);
		repeat (4) @(posedge clk);
		chk(io_out[0], 1'b0, "cleared output");
		apb(1'b0, ADDR_QSTAT, 32'h0);
		chk(rd, 32'h0, "cleared registers");
		apb(1'b1, 12'h400, 32'h900);
		repeat (4) @(posedge clk);
		chk(io_out[0], 1'b1, "inverted cleared output");
		i = 0;
		do
		begin
			apb(1'b0, ADDR_STATUS, 32'h0);
			i++;
		end
		while (rd[STAT_DONE_BIT] !== 1'b1 && i < 800);
		if (rd[STAT_DONE_BIT] !== 1'b1)
			tmo("clear timeout");
		chk(cyc - t0 <= POWERUP_CLEAR_CYC + 6, 1'b1, "clear too long");
		$display("test powerup done");
		for (i = 0; i < 18; i++)
		begin
			apb(1'b1, 12'(12'h800 + 8 * i), (i % 9 == 0) ? 32'h1 :
				(i % 9 == 1) ? 32'h2 : (i % 9 == 8) ? 32'h8 : 32'h1);
			apb(1'b1, 12'(12'h804 + 8 * i),
				(i % 9 >= 2 && i % 9 <= 7) ? 32'h1 : 32'h0);
		end
		foreach (rows[r])
		begin
			set_cfg(rows[r].cfg);
			ded_val <= rows[r].ded;
			pulse(rows[r].bank);
			apb(1'b0, ADDR_QSTAT, 32'h0);
			chk(rd[0], rows[r].q, "register state");
			chk(io_out[0], rows[r].q ^ rows[r].cfg[8], "pin level");
			chk(io_oe[0], 1'b1, "enable by term");
		end
		$display("test table done");
		ded_val <= 4'h0;
		repeat (5) @(posedge clk);
		chk(io_oe[0], 1'b0, "pin clock enable");
		chk(io_oe[1], 1'b0, "combinatorial enable");
		chk(io_out[1], 1'b0, "low terms");
		ded_val <= 4'h2;
		repeat (5) @(posedge clk);
		chk(io_out[1], 1'b1, "sum of terms");
		ded_val <= 4'h0;
		set_cfg(12'h880);
		repeat (5) @(posedge clk);
		chk(io_oe[0], 1'b1, "term clock enable");
		ded_val <= 4'h8;
		repeat (8) @(posedge clk);
		apb(1'b0, ADDR_QSTAT, 32'h0);
		chk(rd[0], 1'b0, "term clocked load");
		$display("test enables done");
		apb(1'b1, 12'h400, 32'h800);
		chk(err, 1'b1, "write while running");
		apb(1'b0, 12'h400, 32'h0);
		chk(rd, 32'h880, "config kept");
		apb(1'b0, 12'h010, 32'h0);
		chk(err, 1'b1, "unmapped error");
		chk(rd, 32'h0, "unmapped data");
		$display("test refusal done");
		// Term 9 reads the feedback of macrocell 0; its pin is released.
		apb(1'b1, ADDR_CTRL, 32'h0);
		apb(1'b1, 12'h848, 32'h10);
		ded_val <= 4'h0;
		set_cfg(12'h840);
		repeat (5) @(posedge clk);
		chk(io_out[1], 1'b1, "pin feedback");
		set_cfg(12'he40);
		repeat (5) @(posedge clk);
		chk(io_out[1], 1'b0, "register feedback");
		$display("test feedback done");
		nrst <= 1'b0;
		repeat (3) @(posedge clk);
		chk(io_oe, 16'hffff, "reset enables");
		chk(io_out, 16'hffff, "reset outputs");
		nrst <= 1'b1;
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk(rd, 32'h0, "clear restarts");
		$display("test reset done");
		test_done();
	end
endmodule
`default_nettype wire
